/* rtl/rse_consts.svh */
// Constants for the nibble-correcting memory EDAC block
`ifndef RSE_CONSTS_SVH
`define RSE_CONSTS_SVH
`define RSE_DATA_W    64
`define RSE_CHK_W     32
`define RSE_CODEC_D   32
`define RSE_CODEC_C   8
`define RSE_NARROW_D  16
`define RSE_QUAD_N    4
`define RSE_DUAL_N    2
`define RSE_ADDR_W    31
`define RSE_BANK_W    3
`define RSE_COL_W     12
`define RSE_ROW_W     15
`define RSE_COL_MIN   9
`define RSE_COL_MAX   12
`define RSE_ROW_MAX   15
`define RSE_GF_POLY   4'h3
`define RSE_ALPHA8    4'h5
`define RSE_ALPHA9    4'hA
`define RSE_ENC_INV   4'h8
`define RSE_SYMS      10
`define RSE_DATA_SYMS 8
`define RSE_NARROW_SYMS 4
`endif

/* rtl/rse_pkg.sv */
// Types and Galois-field helpers for the memory EDAC block
`include "rse_consts.svh"
package rse_pkg;
  typedef struct packed
  {
    logic                    valid;
    logic                    write;
    logic                    diag;
    logic [`RSE_ADDR_W-1:0]  addr;
    logic [`RSE_DATA_W-1:0]  data;
    logic [`RSE_CHK_W-1:0]   check;
  } rse_req_type;

  typedef struct packed
  {
    logic [`RSE_CHK_W-1:0]   check;
    logic [`RSE_DATA_W-1:0]  data;
  } rse_memword_type;

  typedef struct packed
  {
    logic                    valid;
    logic                    write;
    logic [1:0]              csN;
    logic [`RSE_BANK_W-1:0]  bank;
    logic [`RSE_ROW_W-1:0]   row;
    logic [`RSE_COL_W-1:0]   col;
    rse_memword_type         word;
  } rse_cmd_type;

  typedef struct packed
  {
    logic                    valid;
    logic                    error;
    logic [`RSE_DATA_W-1:0]  data;
    logic [`RSE_CHK_W-1:0]   check;
  } rse_rsp_type;

  typedef enum logic [1:0]
  {
    RSE_IDLE = 2'b01,
    RSE_WAIT = 2'b10
  } rse_state_type;

  // GF(16) product, field polynomial x^4+x+1
  function automatic logic [3:0] gfMul(input logic [3:0] a,
                                       input logic [3:0] b);
    logic [3:0] r;
    logic [3:0] s;
    r = 4'h0;
    s = a;
    for (int i = 0; i < 4; i++)
    begin
      if (b[i])
        r = r ^ s;
      s = s[3] ? ({s[2:0], 1'b0} ^ `RSE_GF_POLY) : {s[2:0], 1'b0};
    end
    return r;
  endfunction

  // Locator weight of symbol position i
  function automatic logic [3:0] gfAlpha(input int i);
    logic [3:0] r;
    r = 4'h1;
    for (int k = 0; k < 15; k++)
    begin
      if (k < i)
        r = r[3] ? ({r[2:0], 1'b0} ^ `RSE_GF_POLY) : {r[2:0], 1'b0};
    end
    return r;
  endfunction
endpackage

/* rtl/rse_codec.sv */
// One nibble-correcting base codec: 32 data bits, 8 check bits
`timescale 1ns/10ps
`include "rse_consts.svh"
module rse_codec
  import rse_pkg::*;
(
  input  wire logic [`RSE_CODEC_D-1:0] dataIn,
  input  wire logic [`RSE_CODEC_C-1:0] checkIn,
  input  wire logic                    narrow,
  output logic      [`RSE_CODEC_C-1:0] checkOut,
  output logic      [`RSE_CODEC_D-1:0] dataOut,
  output logic                         corrected,
  output logic                         uncorr
);
  logic [`RSE_CODEC_D-1:0] d;
  logic [3:0]              p0;
  logic [3:0]              p1;
  logic [3:0]              c8;
  logic [3:0]              s0;
  logic [3:0]              s1;
  logic                    found;
  logic [3:0]              loc;

  always_comb
  begin
    // Narrow form is the wide codec with upper symbols held at zero
    d = narrow ? {{(`RSE_CODEC_D-`RSE_NARROW_D){1'b0}},
                  dataIn[`RSE_NARROW_D-1:0]} : dataIn;
    p0 = 4'h0;
    p1 = 4'h0;
    for (int i = 0; i < `RSE_DATA_SYMS; i++)
    begin
      p0 = p0 ^ d[4*i +: 4];
      p1 = p1 ^ gfMul(d[4*i +: 4], gfAlpha(i));
    end
    // Two check symbols zero both syndromes
    c8 = gfMul(p1 ^ gfMul(p0, `RSE_ALPHA9), `RSE_ENC_INV);
    checkOut = {p0 ^ c8, c8};
    s0 = p0 ^ checkIn[3:0] ^ checkIn[7:4];
    s1 = p1 ^ gfMul(checkIn[3:0], `RSE_ALPHA8)
            ^ gfMul(checkIn[7:4], `RSE_ALPHA9);
    found = 1'b0;
    loc = 4'h0;
    for (int j = 0; j < `RSE_SYMS; j++)
    begin
      // Padded positions can never hold an error
      if (s0 != 4'h0 && gfMul(s0, gfAlpha(j)) == s1 && !found &&
          (!narrow || j < `RSE_NARROW_SYMS || j >= `RSE_DATA_SYMS))
      begin
        found = 1'b1;
        loc = 4'(j);
      end
    end
    corrected = found;
    uncorr = ((s0 | s1) != 4'h0) && !found;
    dataOut = d;
    if (found && loc < 4'(`RSE_DATA_SYMS))
      dataOut[4*loc +: 4] = d[4*loc +: 4] ^ s0;
  end
endmodule

/* rtl/rse_edac.sv */
// Reed-Solomon protected memory word path with check-bit diagnostics
`timescale 1ns/10ps
`include "rse_consts.svh"
module rse_edac
  import rse_pkg::*;
#(
  parameter int COL_BITS  = `RSE_COL_MAX,
  parameter int ROW_BITS  = `RSE_ROW_MAX,
  parameter int DDR_RATIO = 1,
  parameter int BUS_W     = `RSE_DATA_W
)
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               encQuad,
  input  wire logic               memTypeDdr,
  input  wire rse_pkg::rse_req_type     req,
  output logic                    reqReady,
  output rse_pkg::rse_cmd_type    memCmd,
  input  wire logic               memRdValid,
  input  wire rse_pkg::rse_memword_type memRdWord,
  output rse_pkg::rse_rsp_type    rsp,
  output logic                    corrPulse,
  output logic                    ddrSel,
  output logic                    sdrSel
);
  import rse_pkg::*;

  // Ratio limited to 1x or 2x
  // Only the 64-bit lane set is built
  if (COL_BITS < `RSE_COL_MIN || COL_BITS > `RSE_COL_MAX ||
      ROW_BITS < 1 || ROW_BITS > `RSE_ROW_MAX ||
      COL_BITS + ROW_BITS + `RSE_BANK_W + 1 > `RSE_ADDR_W ||
      (DDR_RATIO != 1 && DDR_RATIO != 2) || BUS_W != `RSE_DATA_W)
  begin : gBadParam
    $error("rse_edac: unsupported parameter value");
  end

  rse_state_type   state_q;
  rse_state_type   state_d;
  logic            reqReady_q;
  logic            reqReady_d;
  rse_cmd_type     cmd_q;
  rse_cmd_type     cmd_d;
  rse_rsp_type     rsp_q;
  rse_rsp_type     rsp_d;
  logic            corr_q;
  logic            corr_d;
  logic            diag_q;
  logic            diag_d;
  logic            typeSync1_q;
  logic            typeSync2_q;
  logic            typeDone_q;
  logic            typeDone_d;
  logic            ddr_q;
  logic            ddr_d;

  rse_memword_type                  src;
  logic [`RSE_CODEC_D-1:0]          cDataIn  [`RSE_QUAD_N];
  logic [`RSE_CODEC_C-1:0]          cChkIn   [`RSE_QUAD_N];
  logic [`RSE_CODEC_C-1:0]          cChkOut  [`RSE_QUAD_N];
  logic [`RSE_CODEC_D-1:0]          cDataOut [`RSE_QUAD_N];
  logic [`RSE_QUAD_N-1:0]           cCorr;
  logic [`RSE_QUAD_N-1:0]           cUncorr;
  logic [`RSE_DATA_W-1:0]           fixedData;
  logic [`RSE_CHK_W-1:0]            encCheck;

  // Split a word address into column, bank, row and chip
  function automatic rse_cmd_type mapAddr(input logic [`RSE_ADDR_W-1:0] a);
    rse_cmd_type c;
    c = '0;
    c.col  = `RSE_COL_W'(a & ((`RSE_ADDR_W'(1) << COL_BITS) - 1'b1));
    c.bank = `RSE_BANK_W'(a >> COL_BITS);
    c.row  = `RSE_ROW_W'((a >> (COL_BITS + `RSE_BANK_W)) &
                         ((`RSE_ADDR_W'(1) << ROW_BITS) - 1'b1));
    c.csN  = a[COL_BITS + `RSE_BANK_W + ROW_BITS] ? 2'h1 : 2'h2;
    return c;
  endfunction

  // Codecs see read data while waiting, else the write request
  always_comb
  begin
    src.data  = (state_q == RSE_WAIT) ? memRdWord.data  : req.data;
    src.check = (state_q == RSE_WAIT) ? memRdWord.check : req.check;
  end

  for (genvar k = 0; k < `RSE_QUAD_N; k++)
  begin : gCodec
    // Quad lanes take 16 data bits each
    // Dual lanes take 32 bits; upper pair idle
    // Narrow lanes pad their upper data with zeros
    always_comb
    begin
      cChkIn[k] = src.check[8*k +: 8];
      if (encQuad)
        cDataIn[k] = {16'h0000, src.data[16*k +: 16]};
      else if (k < `RSE_DUAL_N)
        cDataIn[k] = src.data[32*k +: 32];
      else
      begin
        cDataIn[k] = '0;
        cChkIn[k] = '0;
      end
    end

    rse_codec uCodec
    (
      .dataIn    (cDataIn[k]),
      .checkIn   (cChkIn[k]),
      .narrow    (encQuad),
      .checkOut  (cChkOut[k]),
      .dataOut   (cDataOut[k]),
      .corrected (cCorr[k]),
      .uncorr    (cUncorr[k])
    );
  end

  // Interleave chosen by the encQuad setting
  always_comb
  begin
    fixedData = '0;
    encCheck  = '0;
    for (int k = 0; k < `RSE_QUAD_N; k++)
    begin
      if (encQuad)
      begin
        fixedData[16*k +: 16] = cDataOut[k][15:0];
        encCheck[8*k +: 8]    = cChkOut[k];
      end
      else if (k < `RSE_DUAL_N)
      begin
        fixedData[32*k +: 32] = cDataOut[k];
        encCheck[8*k +: 8]    = cChkOut[k];
      end
    end
  end

  // Memory type strap, caught once after reset release
  always_comb
  begin
    typeDone_d = 1'b1;
    ddr_d = typeDone_q ? ddr_q : typeSync2_q;
  end

  always_ff @(posedge sys_clk)
  begin
    typeSync1_q <= memTypeDdr;
    typeSync2_q <= typeSync1_q;
    if (!rst_n)
    begin
      typeDone_q <= 1'b0;
      ddr_q      <= 1'b0;
      ddrSel     <= 1'b0;
      sdrSel     <= 1'b0;
    end
    else
    begin
      typeDone_q <= typeDone_d;
      ddr_q      <= ddr_d;
      ddrSel     <= typeDone_q & ddr_q;
      sdrSel     <= typeDone_q & ~ddr_q;
    end
  end

  // Request sequencing
  always_comb
  begin
    state_d = state_q;
    cmd_d   = '0;
    rsp_d   = '0;
    corr_d  = 1'b0;
    diag_d  = diag_q;
    unique case (state_q)
      RSE_IDLE:
      begin
        if (req.valid && reqReady_q)
        begin
          cmd_d = mapAddr(req.addr);
          cmd_d.valid = 1'b1;
          cmd_d.write = req.write;
          diag_d = req.diag;
          if (req.write)
          begin
            // 64 data plus up to 32 check bits
            cmd_d.word.data = req.data;
            // Diagnostic write stores given check bits
            cmd_d.word.check = req.diag ? req.check : encCheck;
            rsp_d.valid = 1'b1;
          end
          else
            state_d = RSE_WAIT;
        end
      end
      RSE_WAIT:
      begin
        if (memRdValid)
        begin
          state_d = RSE_IDLE;
          rsp_d.valid = 1'b1;
          rsp_d.check = memRdWord.check;
          if (diag_q)
            rsp_d.data = memRdWord.data;
          else
          begin
            rsp_d.data = fixedData;
            rsp_d.error = |cUncorr;
            corr_d = |cCorr;
          end
        end
      end
    endcase
    // No new request until the memory type is known
    reqReady_d = (state_d == RSE_IDLE) && typeDone_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q    <= RSE_IDLE;
      reqReady_q <= 1'b0;
      cmd_q      <= '0;
      rsp_q      <= '0;
      corr_q     <= 1'b0;
      diag_q     <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      reqReady_q <= reqReady_d;
      cmd_q      <= cmd_d;
      rsp_q      <= rsp_d;
      corr_q     <= corr_d;
      diag_q     <= diag_d;
    end
  end

  assign reqReady  = reqReady_q;
  assign memCmd    = cmd_q;
  assign rsp       = rsp_q;
  assign corrPulse = corr_q;
endmodule

/* tb/rse_edac_properties.sv */
// Port-level checks of the memory EDAC word path
`timescale 1ns/10ps
module rse_edac_properties
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 encQuad,
  input wire rse_pkg::rse_req_type req,
  input wire logic                 reqReady,
  input wire rse_pkg::rse_cmd_type memCmd,
  input wire logic                 memRdValid,
  input wire rse_pkg::rse_rsp_type rsp,
  input wire logic                 corrPulse,
  input wire logic                 ddrSel,
  input wire logic                 sdrSel
);
  import rse_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = req.valid && reqReady;
  a_write_ack:
    assert property (take && req.write |=> memCmd.valid && memCmd.write
      && rsp.valid && !rsp.error) else $error("write not answered");
  a_read_issue:
    assert property (take && !req.write |=> memCmd.valid
      && !memCmd.write && !reqReady && !rsp.valid)
    else $error("read not issued");
  a_read_answer:
    assert property (memRdValid && !reqReady && (ddrSel != sdrSel)
      |=> rsp.valid && reqReady) else $error("read not answered");
  a_dual_pad:
    assert property (take && req.write && !req.diag && !encQuad
      |=> memCmd.word.check[31:16] == 16'h0000)
    else $error("dual upper check not zero");
  a_diag_raw:
    assert property (take && req.write && req.diag
      |=> memCmd.word.check == $past(req.check))
    else $error("diagnostic check altered");
  a_corr_pulse:
    assert property (corrPulse |-> rsp.valid ##1 !corrPulse)
    else $error("corrected pulse malformed");
  a_err_valid:
    assert property (rsp.error |-> rsp.valid) else $error("stray error");
  a_cs_onehot:
    assert property (memCmd.valid |-> memCmd.csN == 2'b01
      || memCmd.csN == 2'b10) else $error("chip select not one-hot");
  a_one_type:
    assert property (!(ddrSel && sdrSel)) else $error("both types on");
  c_write: cover property (take && req.write);
  c_corr: cover property (corrPulse);
  c_err: cover property (rsp.error);
  c_dual: cover property (take && !encQuad);
endmodule

bind rse_edac rse_edac_properties u_props
(
  .sys_clk(sys_clk), .rst_n(rst_n), .encQuad(encQuad), .req(req),
  .reqReady(reqReady), .memCmd(memCmd), .memRdValid(memRdValid),
  .rsp(rsp), .corrPulse(corrPulse), .ddrSel(ddrSel), .sdrSel(sdrSel)
);

/* tb/rse_mem_model.sv */
// Behavioural memory behind the EDAC word path
`timescale 1ns/10ps
module rse_mem_model
(
  input  wire logic                 sys_clk,
  input  wire rse_pkg::rse_cmd_type memCmd,
  input  wire logic [95:0]          flip,
  input  wire logic [3:0]           lat,
  output rse_pkg::rse_memword_type  memRdWord,
  output logic                      memRdValid
);
  import rse_pkg::*;
  rse_memword_type mem [logic [31:0]];
  logic [31:0]     key;
  logic [31:0]     rdKey;
  int              waitC = 0;
  assign key = {memCmd.csN, memCmd.bank, memCmd.row, memCmd.col};
  initial memRdValid = 1'b0;
  initial memRdWord = '0;
  always @(posedge sys_clk)
  begin
    memRdValid <= 1'b0;
    // Toggle outside a read so stale data never looks valid
    memRdWord <= ~memRdWord;
    if (memCmd.valid && memCmd.write)
      mem[key] = memCmd.word;
    if (memCmd.valid && !memCmd.write)
    begin
      waitC = lat;
      rdKey = key;
    end
    else if (waitC > 0)
    begin
      waitC--;
      if (waitC == 0)
      begin
        memRdValid <= 1'b1;
        memRdWord <= (mem.exists(rdKey) ? mem[rdKey] : '0) ^ flip;
      end
    end
  end
endmodule

/* tb/rse_edac_test.sv */
// Self-checking bench for the memory EDAC word path
`timescale 1ns/10ps
module rse_edac_test;
  import rse_pkg::*;
  localparam logic [63:0] DW = 64'h0123_4567_89AB_CDEF;
  localparam logic [31:0] CK = 32'hA5C3_3C5A;
  localparam logic [30:0] AD = {8'h00, 1'b1, 10'h2A5, 3'h5, 9'h1C3};
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            encQuad = 1'b1;
  logic            memTypeDdr = 1'b1;
  logic            reqReady, memRdValid, corrPulse, ddrSel, sdrSel, corrQ;
  logic [95:0]     flip = '0;
  logic [3:0]      lat = 4'h1;
  rse_req_type     req = '0;
  rse_cmd_type     memCmd, cmdQ;
  rse_memword_type memRdWord;
  rse_rsp_type     rsp, rspQ;
  int              error_cnt = 0;
  int              checks_done = 0;
  int              cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  rse_edac #(.COL_BITS(9), .ROW_BITS(10), .DDR_RATIO(2)) u_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .encQuad(encQuad),
    .memTypeDdr(memTypeDdr), .req(req), .reqReady(reqReady),
    .memCmd(memCmd), .memRdValid(memRdValid), .memRdWord(memRdWord),
    .rsp(rsp), .corrPulse(corrPulse), .ddrSel(ddrSel), .sdrSel(sdrSel)
  );
  rse_mem_model u_mem
  (
    .sys_clk(sys_clk), .memCmd(memCmd), .flip(flip), .lat(lat),
    .memRdWord(memRdWord), .memRdValid(memRdValid)
  );

  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask

  // One request, held until taken; answer captured when it shows
  task automatic xfer(input logic w, input logic dg, input logic [30:0] a,
                      input logic [63:0] d, input logic [31:0] c);
    req = '{1'b1, w, dg, a, d, c};
    do @(posedge sys_clk); while (reqReady !== 1'b1);
    #1;
    // Writes keep valid up; every write is chained by a next call
    if (!w)
      req.valid = 1'b0;
    cmdQ = memCmd;
    while (rsp.valid !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
    rspQ = rsp;
    corrQ = corrPulse;
  endtask

  // Back-to-back writes to both chips, then read back
  task automatic t_rw(input logic q);
    encQuad = q;
    lat = q ? 4'h1 : 4'h6;
    flip = '0;
    for (int b = 0; b < 2; b++)
    begin
      xfer(1'b1, 1'b0, AD ^ {8'h00, b[0], 22'h0}, DW, '0);
      chk({cmdQ.csN, cmdQ.bank, cmdQ.row, cmdQ.col},
          {b[0] ? 2'b10 : 2'b01, 3'h5, 15'h02A5, 12'h1C3});
      chk(cmdQ.word.data, DW);
      if (!q)
        chk(cmdQ.word.check[31:16], 16'h0000);
    end
    for (int b = 0; b < 2; b++)
    begin
      xfer(1'b0, 1'b0, AD ^ {8'h00, b[0], 22'h0}, '0, '0);
      chk({rspQ.error, corrQ, rspQ.data}, {2'b00, DW});
    end
  endtask

  // Corrupt the stored word and judge the answer
  task automatic t_fix(input logic [95:0] fm, input logic err);
    flip = fm;
    xfer(1'b0, 1'b0, AD, '0, '0);
    chk({rspQ.error, corrQ}, {err, !err});
    if (!err)
      chk(rspQ.data, DW);
  endtask

  task automatic t_diag();
    xfer(1'b1, 1'b1, AD, DW, CK);
    chk(cmdQ.word.check, CK);
    flip = 96'hF;
    xfer(1'b0, 1'b1, AD, '0, '0);
    chk({rspQ.error, corrQ, rspQ.check, rspQ.data},
        {2'b00, CK, DW ^ 64'hF});
  endtask

  // Mid-run reset with each memory type strapped
  task automatic t_sel();
    for (int s = 0; s < 2; s++)
    begin
      rst_n = 1'b0;
      memTypeDdr = s[0];
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      @(posedge sys_clk);
      #1;
      chk({reqReady, ddrSel, sdrSel}, 3'b000);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({ddrSel, sdrSel}, {s[0], !s[0]});
    end
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_rw(1'b1);
    t_fix(96'h000F_000F_000F_000F, 1'b0);
    t_fix(96'h000F_0000_0000_0000_0000_0000, 1'b0);
    t_fix(96'hFF, 1'b1);
    t_rw(1'b0);
    t_fix(96'h0000_000F_0000_000F, 1'b0);
    t_fix(96'hFF, 1'b1);
    t_diag();
    t_sel();
    end_sim();
  end
endmodule
